// *** switch_group.v ***
// protection function switch group with front panel and register access
// Behaviour
// - switches one and two pick basic angle -90, -60, -30 or 0 degrees
// - directional stages operate only within basic angle plus or minus sector
// - switch three sets low-set stage forward at 0, reverse at 1
// - switch four makes low-set stage directional at 0, non-directional at 1
// - switch five makes high-set stage directional at 0, non-directional at 1
// - switch six at 1 takes high-set stage out; it never starts or trips
// - switch seven sets high-set stage forward at 0, reverse at 1
// - switch eight picks two current stages plus voltage, or three voltage stages
// - all switches reset to 0, checksum 0
// - while setting show switch number 1..8 and position, else checksum
// - extra group written from panel submenu 6 or from the serial parameter
// - a stage out of use shows three dashes instead of its setting
`timescale 1ns/100ps
module switch_group (
	input wire clk,
	input wire srst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire panel_setting,
	input wire [2:0] panel_submenu,
	input wire [2:0] panel_cursor,
	input wire panel_write,
	input wire panel_value,
	input wire [8:0] phase_angle,
	input wire low_set_start_raw,
	input wire low_set_trip_raw,
	input wire high_set_start_raw,
	input wire high_set_trip_raw,
	output reg [8:0] basic_angle,
	output reg low_set_reverse,
	output reg low_set_directional,
	output reg high_set_directional,
	output reg high_set_enable,
	output reg high_set_reverse,
	output reg three_voltage_stages,
	output wire low_set_angle_ok,
	output wire high_set_angle_ok,
	output reg low_set_start,
	output reg low_set_trip,
	output reg high_set_start,
	output reg high_set_trip,
	output reg high_set_dashes,
	output reg display_setting,
	output reg [3:0] display_switch_num,
	output reg display_switch_pos,
	output reg [7:0] display_checksum,
	output reg [7:0] extra_switch_group
);
`include "switch_group_defs.vh"

	reg [7:0] protection_function_switches;
	reg [7:0] operation_sector;

	// write channel holding registers; address and data may come in either order
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire do_write;
	wire wr_known;
	wire [7:0] wr_byte;
	wire do_read;
	wire wr_prot;
	wire wr_extra;
	wire wr_sector;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_known = (aw_addr == `OFS_PROT_SWITCHES) || (aw_addr == `OFS_EXTRA_GROUP) ||
		(aw_addr == `OFS_SECTOR) || (aw_addr == `OFS_STATUS) || (aw_addr == `OFS_STAGE);
	assign wr_byte = w_data[7:0];
	// only the low byte lane carries a register, the other lanes are dropped
	assign wr_prot = do_write && w_strb[0] && (aw_addr == `OFS_PROT_SWITCHES);
	assign wr_extra = do_write && w_strb[0] && (aw_addr == `OFS_EXTRA_GROUP);
	assign wr_sector = do_write && w_strb[0] && (aw_addr == `OFS_SECTOR);

	always @(posedge clk) begin
		if (srst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// panel bit edits land after a same-cycle bus write so the operator keeps the last word
	reg [7:0] next_prot;
	reg [7:0] next_extra;
	wire panel_prot_edit;
	wire panel_extra_edit;

	assign panel_prot_edit = panel_write && panel_setting && (panel_submenu == `SUBMENU_PROT);
	assign panel_extra_edit = panel_write && panel_setting && (panel_submenu == `SUBMENU_EXTRA);

	always @* begin
		next_prot = protection_function_switches;
		next_extra = extra_switch_group;
		if (wr_prot) begin
			next_prot = wr_byte;
		end
		if (wr_extra) begin
			next_extra = wr_byte;
		end
		if (panel_prot_edit) begin
			next_prot[panel_cursor] = panel_value;
		end
		if (panel_extra_edit) begin
			next_extra[panel_cursor] = panel_value;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			protection_function_switches <= `PROT_SWITCHES_RESET;
			extra_switch_group <= `EXTRA_GROUP_RESET;
			operation_sector <= `SECTOR_RESET;
		end else begin
			protection_function_switches <= next_prot;
			extra_switch_group <= next_extra;
			if (wr_sector) begin
				operation_sector <= wr_byte;
			end
		end
	end

	// checksum of each group as a weighted sum of the set switches
	wire [7:0] prot_partial [0:8];
	wire [7:0] extra_partial [0:8];
	assign prot_partial[0] = 8'h00;
	assign extra_partial[0] = 8'h00;
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : sum_bits
			assign prot_partial[i + 1] = prot_partial[i] +
				(protection_function_switches[i] ? (8'h01 << i) : 8'h00);
			assign extra_partial[i + 1] = extra_partial[i] +
				(extra_switch_group[i] ? (8'h01 << i) : 8'h00);
		end
	endgenerate

	wire [7:0] prot_sum;
	wire [7:0] extra_sum;
	assign prot_sum = prot_partial[8];
	assign extra_sum = extra_partial[8];

	// angle decode; switch one is the low bit of the code
	always @(posedge clk) begin
		if (srst) begin
			basic_angle <= `ANGLE_M90;
		end else begin
			case ({protection_function_switches[`SW_ANGLE_HI],
				protection_function_switches[`SW_ANGLE_LO]})
				2'b00: basic_angle <= `ANGLE_M90;
				2'b01: basic_angle <= `ANGLE_M60;
				2'b10: basic_angle <= `ANGLE_M30;
				default: basic_angle <= `ANGLE_0;
			endcase
		end
	end

	// flag decode of the switches, registered for clean outputs
	always @(posedge clk) begin
		if (srst) begin
			low_set_reverse <= 1'b0;
			low_set_directional <= 1'b1;
			high_set_directional <= 1'b1;
			high_set_enable <= 1'b1;
			high_set_reverse <= 1'b0;
			three_voltage_stages <= 1'b0;
			high_set_dashes <= 1'b0;
		end else begin
			low_set_reverse <= protection_function_switches[`SW_LOW_REVERSE];
			low_set_directional <= !protection_function_switches[`SW_LOW_NONDIR];
			high_set_directional <= !protection_function_switches[`SW_HIGH_NONDIR];
			high_set_enable <= !protection_function_switches[`SW_HIGH_OFF];
			high_set_reverse <= protection_function_switches[`SW_HIGH_REVERSE];
			three_voltage_stages <= protection_function_switches[`SW_THREE_VOLT];
			high_set_dashes <= protection_function_switches[`SW_HIGH_OFF];
		end
	end

	// in three-voltage mode the current stages measure voltage and skip the angle check
	wire low_dir_eff;
	wire high_dir_eff;
	assign low_dir_eff = low_set_directional && !three_voltage_stages;
	assign high_dir_eff = high_set_directional && !three_voltage_stages;

	direction_check low_check (
		.clk(clk),
		.srst(srst),
		.phase_angle(phase_angle),
		.basic_angle(basic_angle),
		.reverse(low_set_reverse),
		.directional(low_dir_eff),
		.sector(operation_sector),
		.angle_ok(low_set_angle_ok)
	);

	direction_check high_check (
		.clk(clk),
		.srst(srst),
		.phase_angle(phase_angle),
		.basic_angle(basic_angle),
		.reverse(high_set_reverse),
		.directional(high_dir_eff),
		.sector(operation_sector),
		.angle_ok(high_set_angle_ok)
	);

	// low-set stage outputs gated by the angle window only; this stage has no enable
	always @(posedge clk) begin
		if (srst) begin
			low_set_start <= 1'b0;
			low_set_trip <= 1'b0;
		end else begin
			low_set_start <= low_set_start_raw && low_set_angle_ok;
			low_set_trip <= low_set_trip_raw && low_set_angle_ok;
		end
	end

	// an out-of-use high-set stage stays quiet even with its window open
	always @(posedge clk) begin
		if (srst) begin
			high_set_start <= 1'b0;
			high_set_trip <= 1'b0;
		end else begin
			high_set_start <= high_set_start_raw && high_set_angle_ok && high_set_enable;
			high_set_trip <= high_set_trip_raw && high_set_angle_ok && high_set_enable;
		end
	end

	// display: switch number and position while setting, checksum otherwise
	wire [7:0] shown_group;
	wire [7:0] shown_sum;
	assign shown_group = (panel_submenu == `SUBMENU_EXTRA) ? extra_switch_group :
		protection_function_switches;
	assign shown_sum = (panel_submenu == `SUBMENU_EXTRA) ? extra_sum : prot_sum;

	always @(posedge clk) begin
		if (srst) begin
			display_setting <= 1'b0;
			display_switch_num <= 4'h0;
			display_switch_pos <= 1'b0;
		end else begin
			display_setting <= panel_setting;
			if (panel_setting) begin
				display_switch_num <= {1'b0, panel_cursor} + 4'h1;
				display_switch_pos <= shown_group[panel_cursor];
			end else begin
				display_switch_num <= 4'h0;
				display_switch_pos <= 1'b0;
			end
		end
	end

	// checksum runs in setting too, so it is already right on leaving setting
	always @(posedge clk) begin
		if (srst) begin
			display_checksum <= 8'h00;
		end else begin
			display_checksum <= shown_sum;
		end
	end

	// read channel; one read at a time, data taken from flip-flops
	reg [31:0] rd_word;
	reg rd_known;
	wire [31:0] status_word;
	wire [31:0] stage_word;
	// both checksums, the three-voltage flag and the high-set enable in one word, so one read polls them all
	assign status_word = {14'h0, three_voltage_stages, high_set_enable, extra_sum, prot_sum};
	assign stage_word = {23'h0, basic_angle};

	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;

	always @* begin
		rd_word = 32'h00000000;
		rd_known = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
			`OFS_PROT_SWITCHES: rd_word = {24'h000000, protection_function_switches};
			`OFS_EXTRA_GROUP: rd_word = {24'h000000, extra_switch_group};
			`OFS_SECTOR: rd_word = {24'h000000, operation_sector};
			`OFS_STATUS: rd_word = status_word;
			`OFS_STAGE: rd_word = stage_word;
			default: rd_known = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// *** switch_group_defs.vh ***
// constants for the protection function switch group block
`ifndef SWITCH_GROUP_DEFS_VH
`define SWITCH_GROUP_DEFS_VH

// register byte offsets
`define OFS_PROT_SWITCHES 8'h00
`define OFS_EXTRA_GROUP 8'h04
`define OFS_SECTOR 8'h08
`define OFS_STATUS 8'h0c
`define OFS_STAGE 8'h10

// reset values
`define PROT_SWITCHES_RESET 8'h00
`define EXTRA_GROUP_RESET 8'h00
`define SECTOR_RESET 8'h50

// switch positions inside the protection function switches (switch n at bit n-1)
`define SW_ANGLE_LO 0
`define SW_ANGLE_HI 1
`define SW_LOW_REVERSE 2
`define SW_LOW_NONDIR 3
`define SW_HIGH_NONDIR 4
`define SW_HIGH_OFF 5
`define SW_HIGH_REVERSE 6
`define SW_THREE_VOLT 7

// basic angles in degrees, nine bit two's complement
`define ANGLE_M90 9'h1a6
`define ANGLE_M60 9'h1c4
`define ANGLE_M30 9'h1e2
`define ANGLE_0 9'h000

// direction arithmetic in degrees
`define DEG_180 11'h0b4
`define DEG_179 11'h0b3
`define DEG_360 11'h168

// front panel submenus
`define SUBMENU_PROT 3'h1
`define SUBMENU_EXTRA 3'h6

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** direction_check.v ***
// angle window check of one directional current stage
`timescale 1ns/100ps
module direction_check (
	input wire clk,
	input wire srst,
	input wire [8:0] phase_angle,
	input wire [8:0] basic_angle,
	input wire reverse,
	input wire directional,
	input wire [7:0] sector,
	output reg angle_ok
);
`include "switch_group_defs.vh"

	wire signed [10:0] phase_ext;
	wire signed [10:0] basic_ext;
	wire signed [10:0] raw_diff;
	reg signed [10:0] diff;
	reg [10:0] mag;

	assign phase_ext = {{2{phase_angle[8]}}, phase_angle};
	assign basic_ext = {{2{basic_angle[8]}}, basic_angle};
	// reverse direction turns the whole window round by half a turn
	assign raw_diff = phase_ext - basic_ext - (reverse ? $signed(`DEG_180) : 11'sd0);

	always @* begin
		// one wrap either way is enough for the possible operand ranges
		if (raw_diff > $signed(`DEG_179)) begin
			diff = raw_diff - $signed(`DEG_360);
		end else if (raw_diff < -$signed(`DEG_180)) begin
			diff = raw_diff + $signed(`DEG_360);
		end else begin
			diff = raw_diff;
		end
		mag = diff[10] ? (11'd0 - diff) : diff;
	end

	always @(posedge clk) begin
		if (srst) begin
			angle_ok <= 1'b0;
		end else begin
			angle_ok <= !directional || (mag <= {3'h0, sector});
		end
	end
endmodule

// *** switch_group_chk.sv ***
// assertions on the switch group ports
`timescale 1ns/100ps
`include "switch_group_defs.vh"
module switch_group_chk (
	input wire clk,
	input wire srst,
	input wire panel_setting,
	input wire [2:0] panel_cursor,
	input wire [3:0] display_switch_num,
	input wire [8:0] basic_angle,
	input wire high_set_enable,
	input wire high_set_dashes,
	input wire high_set_start,
	input wire high_set_trip,
	input wire low_set_directional,
	input wire low_set_angle_ok,
	input wire high_set_angle_ok,
	input wire three_voltage_stages,
	input wire [7:0] extra_switch_group,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
default clocking @(posedge clk); endclocking
default disable iff (srst);
num_shown_a:
assert property (!$past(srst) && $past(panel_setting) |->
	display_switch_num == {1'b0, $past(panel_cursor)} + 4'h1) else $error("switch number wrong");
num_idle_a:
assert property (!$past(srst) && !$past(panel_setting) |-> display_switch_num == 4'h0)
	else $error("switch number shown outside setting");
reset_values_a:
assert property ($past(srst) |-> basic_angle == `ANGLE_M90 && high_set_enable
	&& extra_switch_group == 8'h00) else $error("reset values wrong");
dashes_shown_a:
assert property (high_set_dashes != high_set_enable) else $error("dashes disagree");
high_off_a:
assert property (!high_set_enable [*3] |=> !high_set_start && !high_set_trip)
	else $error("disabled stage operated");
low_nondir_a:
assert property (!low_set_directional [*3] |=> low_set_angle_ok) else $error("angle not bypassed");
three_volt_a:
assert property (three_voltage_stages [*3] |=> low_set_angle_ok && high_set_angle_ok)
	else $error("three voltage mode not bypassed");
write_done_a:
assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
read_done_a:
assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
endmodule
bind switch_group switch_group_chk i_switch_group_chk (.clk, .srst, .panel_setting,
	.panel_cursor, .display_switch_num, .basic_angle, .high_set_enable, .high_set_dashes,
	.high_set_start, .high_set_trip, .low_set_directional, .low_set_angle_ok,
	.high_set_angle_ok, .three_voltage_stages, .extra_switch_group, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rvalid, .s_axi_rready);

// *** switch_group_bench.sv ***
// self-checking bench for the switch group
`timescale 1ns/100ps
`include "switch_group_defs.vh"
module switch_group_bench;
reg clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
reg s_axi_arvalid = 0, s_axi_rready = 0, panel_setting = 0, panel_write = 0, panel_value = 0;
reg low_set_start_raw = 0, low_set_trip_raw = 0, high_set_start_raw = 0, high_set_trip_raw = 0;
reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
reg [31:0] s_axi_wdata = 0;
reg [3:0] s_axi_wstrb = 4'hf;
reg [2:0] panel_submenu = 0, panel_cursor = 0;
reg [8:0] phase_angle = 0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [8:0] basic_angle;
wire low_set_reverse, low_set_directional, high_set_directional, high_set_enable;
wire high_set_reverse, three_voltage_stages, low_set_angle_ok, high_set_angle_ok;
wire low_set_start, low_set_trip, high_set_start, high_set_trip, high_set_dashes;
wire display_setting, display_switch_pos;
wire [3:0] display_switch_num;
wire [7:0] display_checksum, extra_switch_group;
integer failures = 0, checks_done = 0, i;
switch_group i_switch_group (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .panel_setting, .panel_submenu, .panel_cursor, .panel_write,
	.panel_value, .phase_angle, .low_set_start_raw, .low_set_trip_raw, .high_set_start_raw,
	.high_set_trip_raw, .basic_angle, .low_set_reverse, .low_set_directional,
	.high_set_directional, .high_set_enable, .high_set_reverse, .three_voltage_stages,
	.low_set_angle_ok, .high_set_angle_ok, .low_set_start, .low_set_trip, .high_set_start,
	.high_set_trip, .high_set_dashes, .display_setting, .display_switch_num,
	.display_switch_pos, .display_checksum, .extra_switch_group);
initial begin
	forever #2.5 clk = ~clk;
end
task results; begin
	$display("checks %0d failures %0d", checks_done, failures);
	if (failures == 0 && checks_done > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
end endtask
task chk(input [31:0] got, input [31:0] exp); begin
	checks_done = checks_done + 1;
	if (got !== exp) begin
		failures = failures + 1;
		$display("BAD %0t got %h exp %h", $time, got, exp);
	end
end endtask
// a wait that never ends is a failure, so close the run at once
task lim(input ok); begin
	if (!ok) begin
		failures = failures + 1;
		results;
	end
end endtask
task wr(input [7:0] a, input [31:0] d); integer n; reg done; begin
	done = 0;
	@(posedge clk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	for (n = 0; n < 50 && !done; n = n + 1) begin
		@(posedge clk);
		if (s_axi_awvalid && s_axi_awready)
			s_axi_awvalid <= 1'b0;
		if (s_axi_wvalid && s_axi_wready)
			s_axi_wvalid <= 1'b0;
		if (s_axi_bvalid) begin
			done = 1;
			chk(s_axi_bresp, `RESP_OKAY);
			s_axi_bready <= 1'b0;
		end
	end
	lim(done);
end endtask
task rd(input [7:0] a, input [31:0] ed, input [1:0] er); integer n; reg done; begin
	done = 0;
	@(posedge clk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	for (n = 0; n < 50 && !done; n = n + 1) begin
		@(posedge clk);
		if (s_axi_arvalid && s_axi_arready)
			s_axi_arvalid <= 1'b0;
		if (s_axi_rvalid) begin
			done = 1;
			chk(s_axi_rresp, er);
			if (er == `RESP_OKAY)
				chk(s_axi_rdata, ed);
			s_axi_rready <= 1'b0;
		end
	end
	lim(done);
end endtask
task ph(input [8:0] p, input el, input eh); begin
	phase_angle <= p;
	repeat (4) @(posedge clk);
	chk({low_set_angle_ok, low_set_start, low_set_trip, high_set_angle_ok, high_set_start,
		high_set_trip}, {el, el, el, eh, eh, eh});
end endtask
task pw(input [2:0] sm, input [2:0] cur); begin
	@(posedge clk);
	panel_submenu <= sm;
	panel_cursor <= cur;
	panel_value <= 1'b1;
	panel_write <= 1'b1;
	@(posedge clk);
	panel_write <= 1'b0;
	repeat (2) @(posedge clk);
end endtask
task t_reset; begin
	rd(`OFS_PROT_SWITCHES, 32'h0, `RESP_OKAY);
	chk({display_checksum, basic_angle}, {8'h00, `ANGLE_M90});
end endtask
task t_angle; begin
	for (i = 0; i < 4; i = i + 1) begin
		wr(`OFS_PROT_SWITCHES, i);
		repeat (2) @(posedge clk);
		chk(basic_angle, i == 0 ? `ANGLE_M90 : i == 1 ? `ANGLE_M60 :
			i == 2 ? `ANGLE_M30 : `ANGLE_0);
		chk(display_checksum, i);
	end
end endtask
task t_decode; begin
	for (i = 2; i < 8; i = i + 1) begin
		wr(`OFS_PROT_SWITCHES, 32'h1 << i);
		repeat (2) @(posedge clk);
		chk({three_voltage_stages, high_set_reverse, high_set_enable, high_set_directional,
			low_set_directional, low_set_reverse}, {i == 7, i == 6, i != 5, i != 4,
			i != 3, i == 2});
		chk(display_checksum, 32'h1 << i);
	end
end endtask
// sector stays at 80 degrees, so the window edges are -10 and -170
task t_window; begin
	wr(`OFS_PROT_SWITCHES, 32'h0);
	ph(9'h1a6, 1'b1, 1'b1);
	ph(9'h1f6, 1'b1, 1'b1);
	ph(9'h1f7, 1'b0, 1'b0);
	ph(9'h155, 1'b0, 1'b0);
	wr(`OFS_PROT_SWITCHES, 32'h44);
	ph(9'h05a, 1'b1, 1'b1);
	wr(`OFS_PROT_SWITCHES, 32'h04);
	ph(9'h05a, 1'b1, 1'b0);
	wr(`OFS_PROT_SWITCHES, 32'h18);
	ph(9'h05a, 1'b1, 1'b1);
	wr(`OFS_PROT_SWITCHES, 32'h38);
	phase_angle <= 9'h05a;
	repeat (4) @(posedge clk);
	chk({low_set_start, high_set_angle_ok, high_set_start, high_set_trip}, 4'hc);
	chk(high_set_dashes, 1'b1);
	wr(`OFS_PROT_SWITCHES, 32'h80);
	ph(9'h05a, 1'b1, 1'b1);
	low_set_start_raw <= 1'b0;
	repeat (2) @(posedge clk);
	chk({low_set_start, low_set_trip}, 2'b01);
	low_set_start_raw <= 1'b1;
end endtask
task t_panel; begin
	wr(`OFS_PROT_SWITCHES, 32'h0);
	panel_setting <= 1'b1;
	pw(`SUBMENU_PROT, 3'h5);
	chk({display_setting, display_switch_num, display_switch_pos}, 6'h2d);
	pw(`SUBMENU_EXTRA, 3'h0);
	chk(extra_switch_group, 8'h01);
	pw(3'h2, 3'h1);
	chk(extra_switch_group, 8'h01);
	panel_setting <= 1'b0;
	panel_submenu <= `SUBMENU_EXTRA;
	repeat (2) @(posedge clk);
	chk({display_switch_num, display_checksum}, 12'h001);
	wr(`OFS_EXTRA_GROUP, 32'ha5);
	repeat (2) @(posedge clk);
	chk({extra_switch_group, display_checksum}, 16'ha5a5);
	rd(`OFS_PROT_SWITCHES, 32'h20, `RESP_OKAY);
	rd(8'h40, 32'h0, `RESP_SLVERR);
	rd(`OFS_SECTOR, {24'h0, `SECTOR_RESET}, `RESP_OKAY);
	rd(`OFS_STATUS, 32'h0000a520, `RESP_OKAY);
	rd(`OFS_STAGE, {23'h0, `ANGLE_M90}, `RESP_OKAY);
end endtask
initial begin
	repeat (6) @(posedge clk);
	srst <= 1'b0;
	low_set_start_raw <= 1'b1;
	low_set_trip_raw <= 1'b1;
	high_set_start_raw <= 1'b1;
	high_set_trip_raw <= 1'b1;
	t_reset;
	t_angle;
	t_decode;
	t_window;
	t_panel;
	results;
end
endmodule
